/* File: bench/ecoc_link_model.sv */
// Purpose: receive side of the network link
// Assumes: one byte per valid cycle
// Notes: idle data toggles
`timescale 1ns/10ps
module ecoc_link_model import ecoc_pkg::*; (
  input wire logic clk_i,
  output ecoc_byte_type rx_byte_o,
  output logic rx_valid_o
);
  // ----
  // frame sender
  // ----
  logic [7:0] q[$];
  initial begin
    rx_byte_o = '0;
    rx_valid_o = 1'b0;
  end
  task automatic send(input int gap);
    for (int i = 0; i < q.size(); i++) begin
      repeat (gap) begin
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_byte_o.data <= ~rx_byte_o.data;
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_byte_o <= '{data: q[i], sof: i == 0, eof: i == q.size() - 1};
    end
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o <= '{data: ~rx_byte_o.data, sof: 1'b0, eof: 1'b0};
  endtask : send
endmodule : ecoc_link_model

/* File: bench/ecoc_offload_asserts.sv */
// Purpose: port checks for ecoc_offload
// Assumes: ack and status pulse one cycle late
// Notes: bound at foot
`timescale 1ns/10ps
`include "ecoc_params.svh"
module ecoc_offload_asserts import ecoc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`ECOC_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ecoc_byte_type rx_byte_i,
  input wire logic rx_valid_i,
  input wire logic tx_csum_req_i,
  input wire ecoc_rx_status_type rx_status_o,
  input wire logic rx_status_valid_o,
  input wire logic tx_insert_ok_o
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0 |-> wb_dat_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_st_due; rx_valid_i && rx_byte_i.eof |=> rx_status_valid_o; endproperty
  a_st_due: assert property (p_st_due) else $error("status late");
  property p_st_cause; rx_status_valid_o |-> $past(rx_valid_i) && $past(rx_byte_i.eof); endproperty
  a_st_cause: assert property (p_st_cause) else $error("status without frame end");
  property p_st_hold; $changed(rx_status_o) |-> rx_status_valid_o; endproperty
  a_st_hold: assert property (p_st_hold) else $error("status moved");
  property p_drop; rx_status_valid_o && rx_status_o.drop |-> rx_status_o.csum_err; endproperty
  a_drop: assert property (p_drop) else $error("good frame dropped");
  property p_tx_req; tx_insert_ok_o |-> tx_csum_req_i; endproperty
  a_tx_req: assert property (p_tx_req) else $error("insert without request");
  property p_tx_auth; rx_status_valid_o && rx_status_o.auth_seen |-> !tx_insert_ok_o; endproperty
  a_tx_auth: assert property (p_tx_auth) else $error("insert with auth header");
  c_err: cover property (rx_status_valid_o && rx_status_o.csum_err);
  c_cnt: cover property (wb_ack_o && wb_adr_i == 4'h4);
  c_tx: cover property (tx_insert_ok_o);
endmodule : ecoc_offload_asserts
bind ecoc_offload ecoc_offload_asserts u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .rx_byte_i, .rx_valid_i, .tx_csum_req_i, .rx_status_o, .rx_status_valid_o,
  .tx_insert_ok_o);

/* File: bench/ecoc_offload_test.sv */
// Purpose: self-checking bench for ecoc_offload
// Assumes: ack one cycle after take
// Notes: frames built here, sent by link model
`timescale 1ns/10ps
`include "ecoc_params.svh"
module ecoc_offload_test import ecoc_pkg::*;;
  // ----
  // harness
  // ----
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [`ECOC_ADDR_W-1:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic tx_csum_req_i = 1'b0, miss_nodesc_i = 1'b0, miss_fifo_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rx_valid_i, rx_status_valid_o, tx_insert_ok_o;
  ecoc_byte_type rx_byte_i;
  ecoc_rx_status_type rx_status_o;
  int n_errors = 0;
  int samples_checked = 0;
  always #4 clk_i = ~clk_i;
  ecoc_offload dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .rx_byte_i, .rx_valid_i, .tx_csum_req_i, .miss_nodesc_i, .miss_fifo_i,
    .rx_status_o, .rx_status_valid_o, .tx_insert_ok_o);
  ecoc_link_model u_link (.clk_i, .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i));
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    if (n == 50) n_errors++;
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr
  task automatic rx(input bit au, input int cut, input logic [7:0] bad, input logic [2:0] es, input logic eo);
    logic [7:0] t[$];
    logic [31:0] s;
    int n;
    t = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h00, 8'h0C, 8'h00, 8'h00, 8'hDE, 8'hAD, 8'hBE, 8'hEF};
    s = 32'h0;
    n = 0;
    for (int i = 0; i < 12; i += 2) s += {t[i], t[i+1]};
    s = s[15:0] + s[31:16];
    s = s[15:0] + s[31:16];
    t[6] = ~s[15:8];
    t[7] = ~s[7:0];
    t[9] ^= bad;
    u_link.q = {};
    repeat (12) u_link.q.push_back(8'h00);
    u_link.q = {u_link.q, 8'h86, 8'hDD, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, au ? 8'h28 : 8'h1C, 8'h00, 8'h40};
    repeat (32) u_link.q.push_back(8'h00);
    u_link.q = {u_link.q, au ? 8'h33 : 8'h11, 8'h01};
    repeat (14) u_link.q.push_back(8'h00);
    if (au) begin
      u_link.q = {u_link.q, 8'h11, 8'h01};
      repeat (10) u_link.q.push_back(8'h00);
    end
    u_link.q = {u_link.q, t[0:11-cut]};
    u_link.send(au ? 2 : 0);
    do @(negedge clk_i); while (rx_status_valid_o !== 1'b1 && ++n < 50);
    if (n == 50) n_errors++;
    chk({29'h0, rx_status_o}, {29'h0, es});
    @(negedge clk_i);
    chk({31'h0, tx_insert_ok_o}, {31'h0, eo});
  endtask : rx
  task automatic miss(input int a, input int b);
    for (int i = 0; i < a || i < b; i++) begin
      @(posedge clk_i);
      miss_nodesc_i <= i < a;
      miss_fifo_i <= i < b;
    end
    @(posedge clk_i);
    miss_nodesc_i <= 1'b0;
    miss_fifo_i <= 1'b0;
  endtask : miss
  // ----
  // tests
  // ----
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 16; i += 4) rd(i[3:0], 32'h0);
    wr(4'h2, 32'hFFFFFFFF);
    rd(4'h2, 32'h0);
    wr(4'hC, 32'h1);
    rd(4'hC, 32'h1);
    tx_csum_req_i <= 1'b1;
    $display("test registers done");
    rx(1'b0, 0, 8'h00, 3'b000, 1'b1);
    rx(1'b1, 0, 8'h00, 3'b010, 1'b0);
    rx(1'b1, 2, 8'h00, 3'b111, 1'b0);
    wr(4'h0, 32'h04000000);
    rd(4'h0, 32'h04000000);
    rx(1'b0, 0, 8'h01, 3'b100, 1'b1);
    rd(4'h8, 32'h4);
    tx_csum_req_i <= 1'b0;
    @(negedge clk_i);
    chk({31'h0, tx_insert_ok_o}, 32'h0);
    tx_csum_req_i <= 1'b1;
    wr(4'hC, 32'h0);
    @(negedge clk_i);
    chk({31'h0, tx_insert_ok_o}, 32'h0);
    $display("test checksum done");
    miss(3, 2);
    rd(4'h4, 32'h00040003);
    rd(4'h4, 32'h0);
    miss(65537, 65537);
    rd(4'h4, 32'h10030001);
    rd(4'h4, 32'h0);
    $display("test counters done");
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    give_verdict();
  end
endmodule : ecoc_offload_test

/* File: logic/ecoc_csum_acc.sv */
// Purpose: ones-complement 16-bit sum over a byte stream
// Assumes: bytes arrive in network order
// Notes: used once, receive direction only
`timescale 1ns/10ps
module ecoc_csum_acc (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic add_i,
  input wire logic [7:0] byte_i,
  input wire logic odd_i,
  output logic [15:0] sum_o
);
  logic [15:0] sum_ff;
  logic [15:0] nxt_sum;
  logic [16:0] wide;
  always_comb begin
    wide = {1'b0, sum_ff} + (odd_i ? {9'h000, byte_i} : {1'b0, byte_i, 8'h00});
    nxt_sum = sum_ff;
    if (clear_i) begin
      nxt_sum = 16'h0000;
    end else if (add_i) begin
      nxt_sum = wide[15:0] + {15'h0000, wide[16]};
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sum_ff <= 16'h0000;
    end else begin
      sum_ff <= nxt_sum;
    end
  end
  assign sum_o = sum_ff;
endmodule : ecoc_csum_acc

/* File: logic/ecoc_offload.sv */
// Purpose: receive payload checksum check with ipv6 extension walk, missed-frame counters
// Assumes: one byte per cycle on rx stream, tx permit reuses the rx walker's auth flag
// Notes: Wishbone classic slave, ack one cycle after stb
// Functional notes
// - transmit offload computes and inserts ipv4 header or transport checksum per packet; here only the tx_insert_ok_o permit is produced
// - base ipv6 header is 40 bytes; extension headers walked to payload start
// - extension size is length times N plus 8; N=4 auth, else 8
// - fewer payload bytes than declared length reports payload checksum error
// - transmit ipv6 with auth header skips insertion, packet unchanged
// - receive computes transport checksum, mismatch sets payload error status
// - payload length differing from ip header expectation sets payload error
// - error frames dropped unless forward bit 26 of operation mode set
// - two missed-frame counters: no descriptor, and fifo overflow
// - overflow flags at bits 16 and 28 set on counter rollover
// - flags stay set until register read; second rollover keeps them
//
// Local design decisions: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "ecoc_params.svh"
module ecoc_offload import ecoc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`ECOC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ecoc_byte_type rx_byte_i,
  input wire logic rx_valid_i,
  input wire logic tx_csum_req_i,
  input wire logic miss_nodesc_i,
  input wire logic miss_fifo_i,
  output ecoc_rx_status_type rx_status_o,
  output logic rx_status_valid_o,
  output logic tx_insert_ok_o
);
  // ---------------------------------------------------------------
  // registers and bus
  // ---------------------------------------------------------------
  logic forward_csum_error_frames_ff, nxt_forward;
  logic tx_offload_en_ff, nxt_tx_en;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic [`ECOC_NODESC_W-1:0] nodesc_cnt_ff, nxt_nodesc_cnt;
  logic [`ECOC_FIFO_W-1:0] fifo_cnt_ff, nxt_fifo_cnt;
  logic nodesc_ovf_ff, nxt_nodesc_ovf, fifo_ovf_ff, nxt_fifo_ovf;
  ecoc_rx_status_type last_status_ff, nxt_last_status;
  logic bus_req, rd_missed;
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign rd_missed = bus_req && !wb_we_i && (wb_adr_i == `ECOC_OFS_MISSED);
  // ---------------------------------------------------------------
  // rx parse state
  // ---------------------------------------------------------------
  ecoc_state_type st_ff, nxt_st;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] seg_len_ff, nxt_seg_len;
  logic [15:0] pay_len_ff, nxt_pay_len;
  logic [15:0] pay_seen_ff, nxt_pay_seen;
  logic [15:0] etype_ff, nxt_etype;
  logic [7:0] nh_ff, nxt_nh;
  logic [7:0] cur_hdr_ff, nxt_cur_hdr;
  logic is_v6_ff, nxt_is_v6, auth_ff, nxt_auth;
  logic st_valid_ff, nxt_st_valid;
  ecoc_rx_status_type st_out_ff, nxt_st_out;
  logic csum_clear, csum_add;
  logic [15:0] csum_sum;
  logic [7:0] b;
  logic in_pay;
  logic [16:0] fin_wide;
  logic [15:0] fin_sum;
  assign b = rx_byte_i.data;
  // eof byte not yet in the accumulator, fold it in here
  assign fin_wide = {1'b0, csum_sum} + (pay_seen_ff[0] ? {9'h000, b} : {1'b0, b, 8'h00});
  assign fin_sum = fin_wide[15:0] + {15'h0000, fin_wide[16]};
  assign in_pay = (st_ff == ST_PAYLOAD);
  assign csum_clear = rx_valid_i && rx_byte_i.sof;
  assign csum_add = rx_valid_i && in_pay && !rx_byte_i.sof;
  ecoc_csum_acc u_acc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(csum_clear),
    .add_i(csum_add),
    .byte_i(b),
    .odd_i(pay_seen_ff[0]),
    .sum_o(csum_sum)
  );
  function automatic logic is_ext(input logic [7:0] nh);
    is_ext = (nh == `ECOC_NH_HOPOPT) || (nh == `ECOC_NH_ROUTING) ||
             (nh == `ECOC_NH_DSTOPT) || (nh == `ECOC_NH_AUTH);
  endfunction : is_ext
  function automatic logic is_l4(input logic [7:0] nh);
    is_l4 = (nh == `ECOC_NH_TCP) || (nh == `ECOC_NH_UDP) ||
            (nh == `ECOC_NH_ICMP) || (nh == `ECOC_NH_ICMP6);
  endfunction : is_l4
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_seg_len = seg_len_ff;
    nxt_pay_len = pay_len_ff;
    nxt_pay_seen = pay_seen_ff;
    nxt_etype = etype_ff;
    nxt_nh = nh_ff;
    nxt_cur_hdr = cur_hdr_ff;
    nxt_is_v6 = is_v6_ff;
    nxt_auth = auth_ff;
    nxt_st_valid = 1'b0;
    nxt_st_out = st_out_ff;
    if (rx_valid_i) begin
      if (rx_byte_i.sof) begin
        nxt_st = ST_ETH;
        nxt_cnt = 16'h0001;
        nxt_auth = 1'b0;
        nxt_pay_seen = 16'h0000;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
        case (st_ff)
          ST_ETH: begin
            if (cnt_ff == 16'h000C) nxt_etype[15:8] = b;
            if (cnt_ff == 16'h000D) begin
              nxt_etype[7:0] = b;
              nxt_cnt = 16'h0000;
              nxt_is_v6 = ({etype_ff[15:8], b} == `ECOC_ET_IPV6);
              nxt_st = ({etype_ff[15:8], b} == `ECOC_ET_IPV6 || {etype_ff[15:8], b} == `ECOC_ET_IPV4)
                       ? ST_IPHDR : ST_SKIP;
              nxt_seg_len = `ECOC_IPV6_HDR_LEN;
            end
          end
          ST_IPHDR: begin
            if (!is_v6_ff && cnt_ff == 16'h0000) nxt_seg_len = {10'h000, b[3:0], 2'b00};
            if (!is_v6_ff && cnt_ff == 16'h0002) nxt_pay_len[15:8] = b;
            if (!is_v6_ff && cnt_ff == 16'h0003) nxt_pay_len = {pay_len_ff[15:8], b} - seg_len_ff;
            if (!is_v6_ff && cnt_ff == 16'h0009) nxt_nh = b;
            if (is_v6_ff && cnt_ff == 16'h0004) nxt_pay_len[15:8] = b;
            if (is_v6_ff && cnt_ff == 16'h0005) nxt_pay_len[7:0] = b;
            if (is_v6_ff && cnt_ff == 16'h0006) nxt_nh = b;
            if (cnt_ff == seg_len_ff - 16'h0001) begin
              nxt_cnt = 16'h0000;
              nxt_st = is_l4(nh_ff) ? ST_PAYLOAD : (is_v6_ff && is_ext(nh_ff)) ? ST_EXT : ST_SKIP;
              nxt_cur_hdr = nh_ff;
              nxt_seg_len = `ECOC_EXT_BASE;
            end
          end
          ST_EXT: begin
            if (cnt_ff == 16'h0000) nxt_nh = b;
            if (cnt_ff == 16'h0001) begin
              nxt_seg_len = (cur_hdr_ff == `ECOC_NH_AUTH)
                            ? {6'h00, b, 2'b00} + `ECOC_EXT_BASE
                            : {5'h00, b, 3'b000} + `ECOC_EXT_BASE;
              if (cur_hdr_ff == `ECOC_NH_AUTH) nxt_auth = 1'b1;
            end
            if (cnt_ff == seg_len_ff - 16'h0001 && cnt_ff > 16'h0001) begin
              nxt_cnt = 16'h0000;
              nxt_pay_len = pay_len_ff - seg_len_ff;
              nxt_cur_hdr = nh_ff;
              nxt_st = is_l4(nh_ff) ? ST_PAYLOAD : is_ext(nh_ff) ? ST_EXT : ST_SKIP;
            end
          end
          ST_PAYLOAD: begin
            nxt_pay_seen = pay_seen_ff + 16'h0001;
          end
          default: begin
            nxt_st = ST_SKIP;
          end
        endcase
        if (rx_byte_i.eof) begin
          nxt_st_valid = 1'b1;
          nxt_st_out.auth_seen = nxt_auth;
          nxt_st_out.csum_err = 1'b0;
          if (st_ff == ST_PAYLOAD) begin
            nxt_st_out.csum_err = (nxt_pay_seen != pay_len_ff) ||
                                  (fin_sum != 16'hFFFF);
          end
          nxt_st_out.drop = nxt_st_out.csum_err && !forward_csum_error_frames_ff;
        end
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= ST_SKIP;
      cnt_ff <= 16'h0000;
      seg_len_ff <= 16'h0000;
      pay_len_ff <= 16'h0000;
      pay_seen_ff <= 16'h0000;
      etype_ff <= 16'h0000;
      nh_ff <= 8'h00;
      cur_hdr_ff <= 8'h00;
      is_v6_ff <= 1'b0;
      auth_ff <= 1'b0;
      st_valid_ff <= 1'b0;
      st_out_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      seg_len_ff <= nxt_seg_len;
      pay_len_ff <= nxt_pay_len;
      pay_seen_ff <= nxt_pay_seen;
      etype_ff <= nxt_etype;
      nh_ff <= nxt_nh;
      cur_hdr_ff <= nxt_cur_hdr;
      is_v6_ff <= nxt_is_v6;
      auth_ff <= nxt_auth;
      st_valid_ff <= nxt_st_valid;
      st_out_ff <= nxt_st_out;
    end
  end
  assign rx_status_o = st_out_ff;
  assign rx_status_valid_o = st_valid_ff;
  // tx insertion allowed only when enabled, requested and no auth header seen
  assign tx_insert_ok_o = tx_offload_en_ff && tx_csum_req_i && !(is_v6_ff && auth_ff);
  // ---------------------------------------------------------------
  // missed-frame counters and register file
  // ---------------------------------------------------------------
  always_comb begin
    nxt_nodesc_cnt = nodesc_cnt_ff;
    nxt_fifo_cnt = fifo_cnt_ff;
    nxt_nodesc_ovf = nodesc_ovf_ff;
    nxt_fifo_ovf = fifo_ovf_ff;
    if (rd_missed) begin
      nxt_nodesc_cnt = '0;
      nxt_fifo_cnt = '0;
      nxt_nodesc_ovf = 1'b0;
      nxt_fifo_ovf = 1'b0;
    end
    if (miss_nodesc_i) begin
      nxt_nodesc_cnt = nxt_nodesc_cnt + 1'b1;
      if (&nodesc_cnt_ff && !rd_missed) nxt_nodesc_ovf = 1'b1;
    end
    if (miss_fifo_i) begin
      nxt_fifo_cnt = nxt_fifo_cnt + 1'b1;
      if (&fifo_cnt_ff && !rd_missed) nxt_fifo_ovf = 1'b1;
    end
    nxt_forward = forward_csum_error_frames_ff;
    nxt_tx_en = tx_offload_en_ff;
    nxt_ack = bus_req;
    nxt_dat = dat_ff;
    nxt_last_status = rx_status_valid_o ? st_out_ff : last_status_ff;
    if (bus_req && wb_we_i) begin
      if (wb_adr_i == `ECOC_OFS_OPMODE && wb_sel_i[3]) nxt_forward = wb_dat_i[`ECOC_BIT_FWD_ERR];
      if (wb_adr_i == `ECOC_OFS_CTRL && wb_sel_i[0]) nxt_tx_en = wb_dat_i[0];
    end
    if (bus_req && !wb_we_i) begin
      nxt_dat = 32'h00000000;
      case (wb_adr_i)
        `ECOC_OFS_OPMODE: nxt_dat[`ECOC_BIT_FWD_ERR] = forward_csum_error_frames_ff;
        `ECOC_OFS_MISSED: begin
          nxt_dat[`ECOC_NODESC_W-1:0] = nodesc_cnt_ff;
          nxt_dat[`ECOC_BIT_NODESC_OVF] = nodesc_ovf_ff;
          nxt_dat[`ECOC_FIFO_LSB+`ECOC_FIFO_W-1:`ECOC_FIFO_LSB] = fifo_cnt_ff;
          nxt_dat[`ECOC_BIT_FIFO_OVF] = fifo_ovf_ff;
        end
        `ECOC_OFS_STATUS: nxt_dat[2:0] = last_status_ff;
        `ECOC_OFS_CTRL: nxt_dat[0] = tx_offload_en_ff;
        default: nxt_dat = 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nodesc_cnt_ff <= '0;
      fifo_cnt_ff <= '0;
      nodesc_ovf_ff <= 1'b0;
      fifo_ovf_ff <= 1'b0;
      forward_csum_error_frames_ff <= 1'b0;
      tx_offload_en_ff <= 1'b0;
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
      last_status_ff <= '0;
    end else begin
      nodesc_cnt_ff <= nxt_nodesc_cnt;
      fifo_cnt_ff <= nxt_fifo_cnt;
      nodesc_ovf_ff <= nxt_nodesc_ovf;
      fifo_ovf_ff <= nxt_fifo_ovf;
      forward_csum_error_frames_ff <= nxt_forward;
      tx_offload_en_ff <= nxt_tx_en;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      last_status_ff <= nxt_last_status;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
endmodule : ecoc_offload

/* File: logic/ecoc_params.svh */
// Purpose: offsets, field positions, widths, lengths and protocol codes for the checksum offload block
// Assumes: classic Wishbone, 32-bit data, byte addresses
// Notes: definitions only
`ifndef ECOC_PARAMS_SVH
`define ECOC_PARAMS_SVH
`define ECOC_ADDR_W 4
`define ECOC_OFS_OPMODE 4'h0
`define ECOC_OFS_MISSED 4'h4
`define ECOC_OFS_STATUS 4'h8
`define ECOC_OFS_CTRL 4'hC
`define ECOC_BIT_FWD_ERR 26
`define ECOC_BIT_NODESC_OVF 16
`define ECOC_BIT_FIFO_OVF 28
`define ECOC_NODESC_W 16
`define ECOC_FIFO_W 11
`define ECOC_FIFO_LSB 17
`define ECOC_IPV6_HDR_LEN 16'h0028
`define ECOC_EXT_BASE 16'h0008
`define ECOC_ETH_HDR_LEN 16'h000E
`define ECOC_NH_HOPOPT 8'h00
`define ECOC_NH_ROUTING 8'h2B
`define ECOC_NH_DSTOPT 8'h3C
`define ECOC_NH_AUTH 8'h33
`define ECOC_NH_TCP 8'h06
`define ECOC_NH_UDP 8'h11
`define ECOC_NH_ICMP 8'h01
`define ECOC_NH_ICMP6 8'h3A
`define ECOC_ET_IPV4 16'h0800
`define ECOC_ET_IPV6 16'h86DD
`endif

/* File: logic/ecoc_pkg.sv */
// Purpose: types for the checksum offload block
// Assumes: ecoc_params.svh holds offsets, widths and protocol codes; state codes are here
// Notes: byte stream carrier
package ecoc_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic sof;
    logic eof;
  } ecoc_byte_type;
  typedef enum logic [2:0] {
    ST_ETH = 3'b000,
    ST_IPHDR = 3'b001,
    ST_EXT = 3'b010,
    ST_PAYLOAD = 3'b011,
    ST_SKIP = 3'b100
  } ecoc_state_type;
  typedef struct packed {
    logic csum_err;
    logic auth_seen;
    logic drop;
  } ecoc_rx_status_type;
endpackage : ecoc_pkg
